//--- rtl/smc_defines.svh
// smc_defines.svh: offsets, field positions and reset values of the memory control block
// assumes inclusion by bare name from the rtl files of the block
`ifndef SMC_DEFINES_SVH
`define SMC_DEFINES_SVH

// register offsets (word index on the plain register port)
`define SMC_OFF_CONFIG    4'h0
`define SMC_OFF_STATUS    4'h1
`define SMC_OFF_MASK      4'h2
`define SMC_OFF_MACHSTATE 4'h3
`define SMC_OFF_LASTEA    4'h4
`define SMC_OFF_SEGBASE   4'h8

// config register fields
`define SMC_CFG_BCAST     0
`define SMC_CFG_SHADOW    1
`define SMC_CFG_DCDIS     2
`define SMC_CFG_DCLOCK    3

// machine state fields
`define SMC_MS_DTRANS     0
`define SMC_MS_ITRANS     1

// status and mask fields
`define SMC_ST_DONE       0
`define SMC_ST_DSI        1
`define SMC_ST_ILLEGAL    2
`define SMC_ST_SYNCDONE   3
`define SMC_ST_WIDTH      4

// segment register layout: direct-store bit
`define SMC_SEG_DSTORE    31

// index field of the translation entry invalidate (bits 14..19 big-endian = 17..12)
`define SMC_TLB_IDX_LO    12
`define SMC_TLB_IDX_HI    17

// segment select, top nibble of the effective address
`define SMC_SEG_SEL_LO    28

`define SMC_ZERO32        32'h0000_0000
`define SMC_ZERO4         4'h0
`define SMC_ZERO2         2'h0

`endif

//--- rtl/smc_pkg.sv
// smc_pkg.sv: types shared by the memory control block files
// assumes smc_defines.svh is reachable on the include path
package smc_pkg;
  typedef enum logic [2:0]
  {
    SMC_OP_DBLKINV,
    SMC_OP_SEGWR,
    SMC_OP_SEGRD,
    SMC_OP_TLBINV,
    SMC_OP_TLBSYNC,
    SMC_OP_TLBINVALL
  } smc_op_t;

  typedef enum logic [1:0]
  {
    SMC_FLT_NONE,
    SMC_FLT_BLOCK,
    SMC_FLT_PAGE
  } smc_fault_t;
endpackage

//--- rtl/smc_tlb_if.sv
// smc_tlb_if.sv: carries invalidate requests from the sequencer to the buffer model
// assumes one clock domain shared by both ends
`timescale 1ns/100ps
`default_nettype none
interface smc_tlb_if #(parameter int IDXW = 6);
  logic            invStb;   // one-cycle invalidate pulse
  logic [IDXW-1:0] invIdx;   // set index to clear
  logic [IDXW-1:0] probeIdx; // index looked up for a status read
  logic [3:0]      probeVal; // valid bits of both ways in both buffers

  modport seq (output invStb, output invIdx, output probeIdx, input probeVal);
  modport buf_ (input invStb, input invIdx, input probeIdx, output probeVal);
endinterface
`default_nettype wire

//--- rtl/smc_tlb_valid.sv
// smc_tlb_valid.sv: valid bits of the instruction and data translation buffers
// assumes fills arrive on fillStb from the table walker outside this block
`timescale 1ns/100ps
`default_nettype none
`include "smc_defines.svh"
module smc_tlb_valid
  import smc_pkg::*;
#(
  parameter int SETS = 64
)
(
  input  wire logic      clk,      // core clock
  input  wire logic      resetn,   // async reset, active low
  input  wire logic      fillStb,  // mark one way valid
  input  wire logic [5:0] fillIdx, // set of the fill
  input  wire logic [1:0] fillWay, // bit0 way, bit1 data side
  smc_tlb_if.buf_        tlb       // invalidate port
);
  // two ways of two buffers per set
  logic [3:0] valid_reg [SETS];

  // invalidate wins over a fill to the same set: stale entries must go
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < SETS; i++)
        valid_reg[i] <= `SMC_ZERO4;
    end
    else
    begin
      if (fillStb)
        valid_reg[fillIdx][fillWay] <= 1'b1;
      if (tlb.invStb)
        valid_reg[tlb.invIdx] <= `SMC_ZERO4;
    end
  end

  assign tlb.probeVal = valid_reg[tlb.probeIdx];
endmodule
`default_nettype wire

//--- rtl/smc_seg_file.sv
// smc_seg_file.sv: sixteen segment registers plus shadow copies in the fetch side
// assumes writes come from the sequencer, one per cycle
`timescale 1ns/100ps
`default_nettype none
`include "smc_defines.svh"
module smc_seg_file
  import smc_pkg::*;
(
  input  wire logic        clk,      // core clock
  input  wire logic        resetn,   // async reset, active low
  input  wire logic        wrStb,    // segment write
  input  wire logic [3:0]  wrSel,    // segment number
  input  wire logic [31:0] wrData,   // new descriptor
  input  wire logic [3:0]  rdSel,    // read segment number
  input  wire logic        rdShadow, // pick the shadow copy
  output logic      [31:0] rdData,   // selected descriptor
  input  wire logic [3:0]  chkSel,   // segment of a cache op address
  output logic             chkDirect // that segment is direct-store
);
  logic [31:0] seg_reg [16];
  logic [31:0] shadow_reg [16];

  // both copies update together; shadow only diverges by its read path
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < 16; i++)
      begin
        seg_reg[i]    <= `SMC_ZERO32;
        shadow_reg[i] <= `SMC_ZERO32;
      end
    end
    else if (wrStb)
    begin
      seg_reg[wrSel]    <= wrData;
      shadow_reg[wrSel] <= wrData;
    end
  end

  assign rdData    = rdShadow ? shadow_reg[rdSel] : seg_reg[rdSel];
  assign chkDirect = seg_reg[chkSel][`SMC_SEG_DSTORE];
endmodule
`default_nettype wire

//--- rtl/smc_memctl.sv
// smc_memctl.sv: supervisor memory control operations and their register port
// assumes the cache, translation lookup and bus are outside and answer in the same cycle
//
// Added by the designer: the address map and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
`include "smc_defines.svh"

module smc_memctl
  import smc_pkg::*;
(
  input  wire logic        clk,                 // core clock, 200 MHz
  input  wire logic        resetn,              // async reset, active low
  input  wire logic        opValid,             // operation offered
  output logic             opReady,             // operation accepted
  input  wire smc_op_t     opCode,              // which operation
  input  wire logic [31:0] opAddr,              // effective address
  input  wire logic [31:0] opData,              // segment write data
  input  wire logic [3:0]  opSeg,               // direct segment number
  input  wire logic        opIndirect,          // segment from address top
  output logic             doneStb,             // operation finished
  output logic [31:0]      resultData,          // segment read result
  output logic             faultDsi,            // storage fault pulse
  output logic             faultIllegal,        // illegal op fault pulse
  output logic [31:0]      xlateAddr,           // address to translate
  output logic             xlateStore,          // translation is a store
  output logic             xlateReq,            // translation lookup pulse
  input  wire logic        xlateBlockViol,      // block array protection hit
  input  wire logic        xlatePageViol,       // page protection hit
  input  wire logic [31:0] xlatePhys,           // physical address
  output logic             cacheLookup,         // data cache probe pulse
  output logic [31:0]      cacheAddr,           // physical address probed
  input  wire logic        cacheHit,            // probe hit
  output logic             cacheInvalidate,     // mark hit block invalid
  output logic             busBcast,            // broadcast the invalidate
  output logic [31:0]      busAddr,             // broadcast address
  input  wire logic        invalidate_sync_input, // external sync busy
  input  wire logic        fillStb,             // buffer fill from walker
  input  wire logic [5:0]  fillIdx,             // fill set
  input  wire logic [1:0]  fillWay,             // fill way and side
  input  wire logic [3:0]  regAddr,             // register index
  input  wire logic [31:0] regWdata,            // register write data
  input  wire logic        regWr,               // write strobe
  input  wire logic        regRd,               // read strobe
  output logic [31:0]      regRdata,            // read data, next cycle
  output logic             irq                  // level interrupt
);
  typedef enum logic [2:0] {S_IDLE, S_XLATE, S_PROBE, S_SYNC} smc_state_t;

  smc_state_t state_reg;
  smc_op_t    op_reg;
  logic [31:0] addr_reg, phys_reg;
  logic [3:0]  config_reg, status_reg, mask_reg;
  logic [1:0]  machstate_reg;
  logic [31:0] lastEa_reg;
  logic [3:0]  evSet;
  logic [31:0] segRd;
  logic        segDirect;
  logic [3:0]  rdSel;

  smc_tlb_if #(.IDXW(6)) tlb ();

  function automatic logic [3:0] seg_of(input logic [31:0] a);
    seg_of = a[31:`SMC_SEG_SEL_LO];
  endfunction

  smc_tlb_valid #(.SETS(64)) u_tlb
  (
    .clk     (clk),
    .resetn  (resetn),
    .fillStb (fillStb),
    .fillIdx (fillIdx),
    .fillWay (fillWay),
    .tlb     (tlb)
  );

  assign rdSel = opIndirect ? seg_of(opAddr) : opSeg;

  // translation enables never reach this file: moves behave the same either way
  smc_seg_file u_seg
  (
    .clk       (clk),
    .resetn    (resetn),
    .wrStb     (opValid && opReady && opCode == SMC_OP_SEGWR),
    .wrSel     (rdSel),
    .wrData    (opData),
    .rdSel     (rdSel),
    .rdShadow  (config_reg[`SMC_CFG_SHADOW]),
    .rdData    (segRd),
    .chkSel    (seg_of(addr_reg)),
    .chkDirect (segDirect)
  );

  assign opReady = (state_reg == S_IDLE);
  wire accept = opValid && opReady;

  // translation entry invalidate acts in the accept cycle, enables ignored
  assign tlb.invStb = accept && opCode == SMC_OP_TLBINV;
  assign tlb.invIdx = opAddr[`SMC_TLB_IDX_HI:`SMC_TLB_IDX_LO];
  assign tlb.probeIdx = lastEa_reg[`SMC_TLB_IDX_HI:`SMC_TLB_IDX_LO];

  // operation sequencer
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_reg <= S_IDLE;
      op_reg    <= SMC_OP_DBLKINV;
      addr_reg  <= `SMC_ZERO32;
      phys_reg  <= `SMC_ZERO32;
    end
    else
    begin
      case (state_reg)
        S_IDLE:
        begin
          if (accept)
          begin
            op_reg   <= opCode;
            addr_reg <= opAddr;
            if (opCode == SMC_OP_DBLKINV)
              state_reg <= S_XLATE;
            else if (opCode == SMC_OP_TLBSYNC)
              state_reg <= S_SYNC;
          end
        end
        S_XLATE:
        begin
          // direct-store segments drop out before any lookup
          if (segDirect || xlateBlockViol || xlatePageViol)
            state_reg <= S_IDLE;
          else
          begin
            phys_reg  <= xlatePhys;
            state_reg <= S_PROBE;
          end
        end
        S_PROBE:
          state_reg <= S_IDLE;
        S_SYNC:
          if (!invalidate_sync_input)
            state_reg <= S_IDLE;
        default:
          state_reg <= S_IDLE;
      endcase
    end
  end

  // translation request: treated as a store
  assign xlateReq   = (state_reg == S_XLATE) && !segDirect;
  assign xlateAddr  = addr_reg;
  assign xlateStore = 1'b1;

  // cache probe ignores disable and lock bits on purpose
  assign cacheLookup     = (state_reg == S_PROBE);
  assign cacheAddr       = phys_reg;
  // only a hit invalidates; a miss still broadcasts when the broadcast bit is set
  assign cacheInvalidate = cacheLookup && cacheHit;

  // result, fault and broadcast outputs from flip-flops
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      doneStb      <= 1'b0;
      resultData   <= `SMC_ZERO32;
      faultDsi     <= 1'b0;
      faultIllegal <= 1'b0;
      busBcast     <= 1'b0;
      busAddr      <= `SMC_ZERO32;
    end
    else
    begin
      doneStb      <= 1'b0;
      faultDsi     <= 1'b0;
      faultIllegal <= 1'b0;
      busBcast     <= 1'b0;
      if (accept && opCode == SMC_OP_SEGRD)
        resultData <= segRd;
      if (accept && opCode == SMC_OP_TLBINVALL)
        faultIllegal <= 1'b1;
      // block fault and page fault both end as a storage fault; block checked first
      if (state_reg == S_XLATE && !segDirect && (xlateBlockViol || xlatePageViol))
        faultDsi <= 1'b1;
      if (cacheLookup && config_reg[`SMC_CFG_BCAST])
      begin
        busBcast <= 1'b1;
        busAddr  <= phys_reg;
      end
      if ((accept && opCode != SMC_OP_DBLKINV && opCode != SMC_OP_TLBSYNC)
          || (state_reg == S_XLATE && (segDirect || xlateBlockViol || xlatePageViol))
          || cacheLookup
          || (state_reg == S_SYNC && !invalidate_sync_input))
        doneStb <= 1'b1;
    end
  end

  // fault class latched for software: block-level fault outranks page-level
  smc_fault_t lastFault_reg;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      lastFault_reg <= SMC_FLT_NONE;
    else if (state_reg == S_XLATE && !segDirect)
    begin
      if (xlateBlockViol)
        lastFault_reg <= SMC_FLT_BLOCK;
      else if (xlatePageViol)
        lastFault_reg <= SMC_FLT_PAGE;
    end
  end

  // last accepted address, kept for the status view
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      lastEa_reg <= `SMC_ZERO32;
    else if (accept)
      lastEa_reg <= opAddr;
  end

  // events feeding the sticky status bits
  always_comb
  begin
    evSet = `SMC_ZERO4;
    evSet[`SMC_ST_DONE]     = doneStb;
    evSet[`SMC_ST_DSI]      = faultDsi;
    evSet[`SMC_ST_ILLEGAL]  = faultIllegal;
    evSet[`SMC_ST_SYNCDONE] = doneStb && op_reg == SMC_OP_TLBSYNC;
  end

  // config, mask and machine state writes
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      config_reg    <= `SMC_ZERO4;
      mask_reg      <= `SMC_ZERO4;
      machstate_reg <= `SMC_ZERO2;
    end
    else if (regWr)
    begin
      if (regAddr == `SMC_OFF_CONFIG)
        config_reg <= regWdata[3:0];
      if (regAddr == `SMC_OFF_MASK)
        mask_reg <= regWdata[3:0];
      if (regAddr == `SMC_OFF_MACHSTATE)
        machstate_reg <= regWdata[1:0];
    end
  end

  // sticky status, write one to clear; a new event wins over the clear
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      status_reg <= `SMC_ZERO4;
    else if (regWr && regAddr == `SMC_OFF_STATUS)
      status_reg <= (status_reg & ~regWdata[3:0]) | evSet;
    else
      status_reg <= status_reg | evSet;
  end

  assign irq = |(status_reg & mask_reg);

  // read port: data stands one cycle after the strobe, zero otherwise
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      regRdata <= `SMC_ZERO32;
    else if (regRd)
    begin
      case (regAddr)
        `SMC_OFF_CONFIG:    regRdata <= {28'h0000000, config_reg};
        `SMC_OFF_STATUS:    regRdata <= {28'h0000000, status_reg};
        `SMC_OFF_MASK:      regRdata <= {28'h0000000, mask_reg};
        `SMC_OFF_MACHSTATE: regRdata <= {30'h00000000, machstate_reg};
        `SMC_OFF_LASTEA:    regRdata <= lastEa_reg;
        `SMC_OFF_SEGBASE:   regRdata <= {22'h000000, state_reg, lastFault_reg,
                                         tlb.probeVal, invalidate_sync_input};
        default:            regRdata <= `SMC_ZERO32;
      endcase
    end
    else
      regRdata <= `SMC_ZERO32;
  end
endmodule
`default_nettype wire

//--- testbench/smc_memctl_props.sv
// smc_memctl_props.sv: port assertions of smc_memctl
// assumes one core clock and the async active low reset
`timescale 1ns/100ps
`default_nettype none
`include "smc_defines.svh"
module smc_memctl_props
  import smc_pkg::*;
(
  input wire logic        clk,                   // clock
  input wire logic        resetn,                // reset
  input wire logic        opValid,               // offer
  input wire logic        opReady,               // accept
  input wire smc_op_t     opCode,                // op
  input wire logic        doneStb,               // done
  input wire logic        faultDsi,              // dsi
  input wire logic        faultIllegal,          // illegal
  input wire logic        xlateReq,              // lookup
  input wire logic        xlateStore,            // store
  input wire logic        xlateBlockViol,        // block viol
  input wire logic        xlatePageViol,         // page viol
  input wire logic        cacheLookup,           // probe
  input wire logic        cacheHit,              // hit
  input wire logic        cacheInvalidate,       // kill
  input wire logic        busBcast,              // bcast
  input wire logic        invalidate_sync_input, // sync busy
  input wire logic [3:0]  regAddr,               // reg index
  input wire logic [31:0] regWdata,              // reg data
  input wire logic        regWr                  // reg write
);
  wire logic take = opValid && opReady;
  logic      bcastReg; // broadcast enable as last written
  logic      syncReg;  // sync op open
  // shadow of the enable bit, so no register read is needed here
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
      bcastReg <= 1'b0;
    else if (regWr && regAddr == `SMC_OFF_CONFIG)
      bcastReg <= regWdata[`SMC_CFG_BCAST];
  // open from the accept edge to its done pulse
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
      syncReg <= 1'b0;
    else if (take && opCode == SMC_OP_TLBSYNC)
      syncReg <= 1'b1;
    else if (doneStb)
      syncReg <= 1'b0;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_store; xlateReq |-> xlateStore; endproperty
  a_store: assert property (p_store) else $error("lookup not a store");
  property p_order; cacheLookup |-> $past(xlateReq); endproperty
  a_order: assert property (p_order) else $error("probe before lookup");
  property p_kill; cacheInvalidate == (cacheLookup && cacheHit); endproperty
  a_kill: assert property (p_kill) else $error("kill not hit");
  property p_fault; xlateReq && (xlateBlockViol || xlatePageViol)
    |=> faultDsi && doneStb && !cacheLookup; endproperty
  a_fault: assert property (p_fault) else $error("fault not taken");
  property p_bcast; cacheLookup |=> doneStb && (busBcast == bcastReg); endproperty
  a_bcast: assert property (p_bcast) else $error("bcast wrong");
  property p_ill; take && opCode == SMC_OP_TLBINVALL |=> faultIllegal && doneStb; endproperty
  a_ill: assert property (p_ill) else $error("no illegal fault");
  property p_tinv; take && opCode == SMC_OP_TLBINV |=> doneStb && !faultDsi; endproperty
  a_tinv: assert property (p_tinv) else $error("entry invalidate");
  property p_seg; take && opCode == SMC_OP_SEGRD |=> doneStb && !xlateReq; endproperty
  a_seg: assert property (p_seg) else $error("seg read");
  property p_hold; syncReg && invalidate_sync_input |=> !doneStb; endproperty
  a_hold: assert property (p_hold) else $error("sync early");
  property p_rel; syncReg && !doneStb && !invalidate_sync_input |=> doneStb; endproperty
  a_rel: assert property (p_rel) else $error("sync late");
  c_kill: cover property (cacheInvalidate);
  c_bcast: cover property (busBcast);
  c_dsi: cover property (faultDsi);
  c_sync: cover property (syncReg && doneStb);
endmodule
bind smc_memctl smc_memctl_props chk_u (.*);
`default_nettype wire

//--- testbench/smc_far_model.sv
// smc_far_model.sv: translation, data cache and sync source facing smc_memctl
// assumes the bench sets the wanted answers before each op
`timescale 1ns/100ps
`default_nettype none
module smc_far_model
(
  input  wire logic        clk,                  // clock
  input  wire logic        resetn,               // reset
  input  wire logic        xlateReq,             // lookup
  input  wire logic [31:0] xlateAddr,            // ea
  input  wire logic        cacheLookup,          // probe
  input  wire logic        wantBlk,              // block viol wanted
  input  wire logic        wantPage,             // page viol wanted
  input  wire logic        wantHit,              // hit wanted
  input  wire logic [7:0]  syncLen,              // busy span, 0 none
  output logic             xlateBlockViol,       // block viol
  output logic             xlatePageViol,        // page viol
  output logic [31:0]      xlatePhys,            // pa
  output logic             cacheHit,             // hit
  output logic             invalidate_sync_input // sync busy
);
  logic       togReg; // junk source
  logic [7:0] cntReg; // busy cycles left
  // answers are valid only with the request; junk otherwise exposes stale use
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
      togReg <= 1'b0;
    else
      togReg <= ~togReg;
  // a new span replaces what is left
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
      cntReg <= 8'h00;
    else if (syncLen != 8'h00)
      cntReg <= syncLen;
    else if (cntReg != 8'h00)
      cntReg <= cntReg - 8'h01;
  assign xlateBlockViol = xlateReq ? wantBlk : togReg;
  assign xlatePageViol = xlateReq ? wantPage : ~togReg;
  assign xlatePhys = xlateReq ? (xlateAddr ^ 32'h0F00_0000) : {32{togReg}};
  assign cacheHit = cacheLookup ? wantHit : togReg;
  assign invalidate_sync_input = (cntReg != 8'h00);
endmodule
`default_nettype wire

//--- testbench/smc_memctl_test.sv
// smc_memctl_test.sv: self-checking bench of smc_memctl
// assumes smc_far_model on the far side and the bound checker
`timescale 1ns/100ps
`default_nettype none
`include "smc_defines.svh"
module smc_memctl_test
  import smc_pkg::*;
;
  logic        clk, resetn, opValid, opReady, opIndirect, doneStb, faultDsi, faultIllegal;
  logic        xlateStore, xlateReq, xlateBlockViol, xlatePageViol, cacheLookup, cacheHit;
  logic        cacheInvalidate, busBcast, invalidate_sync_input, fillStb, regWr, regRd, irq;
  logic        wantBlk, wantPage, wantHit;
  smc_op_t     opCode;
  logic [31:0] opAddr, opData, resultData, xlateAddr, xlatePhys, cacheAddr, busAddr;
  logic [31:0] regWdata, regRdata, rd;
  logic [7:0]  syncLen;
  logic [5:0]  fillIdx;
  logic [3:0]  opSeg, regAddr;
  logic [1:0]  fillWay;
  logic [6:0]  fl; // {illegal, dsi, bcast, kill, probe, lookup, done} seen
  int          err_count, n_checks, cyc;

  smc_memctl dut_u (.*);
  smc_far_model far_u (.*);

  always #2.5 clk = ~clk;

  task automatic check(input logic ok, input string msg);
    n_checks++;
    // an unknown result counts as a mismatch, never as a pass
    if (ok !== 1'b1)
    begin
      err_count++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  // data stands only in the cycle after the strobe
  task automatic rdreg(input logic [3:0] a);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    @(negedge clk);
    rd = regRdata;
  endtask

  // one op, pulses gathered until done; cyc counts cycles after accept
  task automatic op(input smc_op_t c, input logic [31:0] a, d, input logic [3:0] s,
                    input logic ind);
    @(posedge clk);
    opValid <= 1'b1;
    opCode <= c;
    opAddr <= a;
    opData <= d;
    opSeg <= s;
    opIndirect <= ind;
    @(negedge clk);
    check(opReady === 1'b1, "op refused");
    @(posedge clk);
    opValid <= 1'b0;
    fl = 7'h00;
    for (cyc = 0; cyc < 60 && fl[0] !== 1'b1; cyc++)
    begin
      @(negedge clk);
      fl = fl | {faultIllegal, faultDsi, busBcast, cacheInvalidate, cacheLookup, xlateReq, doneStb};
    end
  endtask

  task automatic t_regs();
    logic [3:0] a [4];
    a = '{`SMC_OFF_CONFIG, `SMC_OFF_STATUS, `SMC_OFF_MASK, 4'h7};
    foreach (a[i])
    begin
      rdreg(a[i]);
      check(rd === 32'h0, "reset value");
    end
  endtask

  // cache disabled and locked throughout; every broadcast and hit pairing
  task automatic t_blkinv();
    logic [1:0] k;
    for (int i = 0; i < 4; i++)
    begin
      k = i[1:0];
      wantHit = k[0];
      wr(`SMC_OFF_CONFIG, {28'h0, 2'b11, 1'b0, k[1]});
      op(SMC_OP_DBLKINV, 32'h1234_5000, 32'h0, 4'h0, 1'b0);
      check(fl === {2'b00, k[1], k[0], 3'b111}, "block inv");
      check(busAddr === (k[1] ? 32'h1D34_5000 : 32'h0) && cacheAddr === 32'h1D34_5000
            && xlateAddr === 32'h1234_5000, "addresses");
    end
  endtask

  task automatic t_faults();
    logic [1:0] v;
    for (int i = 1; i < 4; i++)
    begin
      v = i[1:0];
      wantBlk = v[0];
      wantPage = v[1];
      op(SMC_OP_DBLKINV, 32'h1000_0040, 32'h0, 4'h0, 1'b0);
      check(fl === 7'b0100011, "fault");
      rdreg(4'h8);
      check(rd[6:5] === (v[0] ? 2'h1 : 2'h2), "fault class");
    end
    wantBlk = 1'b0;
    wantPage = 1'b0;
    rdreg(`SMC_OFF_STATUS);
    check(rd[`SMC_ST_DSI] === 1'b1 && irq === 1'b0, "dsi flag");
    wr(`SMC_OFF_MASK, 32'h2);
    @(negedge clk);
    check(irq === 1'b1, "irq raise");
    wr(`SMC_OFF_STATUS, 32'hF);
    @(negedge clk);
    check(irq === 1'b0, "irq clear");
    wr(`SMC_OFF_MASK, 32'h0);
  endtask

  task automatic t_direct();
    op(SMC_OP_SEGWR, 32'h0, 32'h8000_0000, 4'h5, 1'b0);
    wantHit = 1'b1;
    op(SMC_OP_DBLKINV, 32'h5000_0100, 32'h0, 4'h0, 1'b0);
    // a no-op: no lookup, no probe, only the done pulse
    check(fl === 7'b0000001, "direct-store");
  endtask

  task automatic t_segs();
    logic [31:0] v;
    for (int m = 0; m < 4; m++)
    begin
      v = 32'h00AB_CD00 | m;
      wr(`SMC_OFF_MACHSTATE, m);
      wr(`SMC_OFF_CONFIG, {30'h0, m[0], 1'b0});
      op(SMC_OP_SEGWR, 32'h0, v, 4'h6, 1'b0);
      op(SMC_OP_SEGRD, 32'h0, 32'h0, 4'h6, 1'b0);
      check(fl === 7'b0000001 && resultData === v, "seg direct");
      op(SMC_OP_SEGWR, 32'h7000_0000, ~v, 4'h0, 1'b1);
      op(SMC_OP_SEGRD, 32'h7000_0000, 32'h0, 4'h0, 1'b1);
      check(fl === 7'b0000001 && resultData === ~v, "seg indirect");
    end
  endtask

  // a miss probe sets the index shown in the debug view without side effects
  task automatic t_tlbinv();
    wr(`SMC_OFF_MACHSTATE, 32'h3);
    wantHit = 1'b0;
    for (int w = 0; w < 5; w++)
    begin
      @(posedge clk);
      fillStb <= 1'b1;
      fillIdx <= (w < 4) ? 6'h2A : 6'h15;
      fillWay <= w[1:0];
    end
    @(posedge clk);
    fillStb <= 1'b0;
    op(SMC_OP_DBLKINV, 32'h0002_A000, 32'h0, 4'h0, 1'b0);
    rdreg(4'h8);
    check(rd[4:1] === 4'hF, "filled");
    op(SMC_OP_TLBINV, 32'h0002_A000, 32'h0, 4'h0, 1'b0);
    check(fl === 7'b0000001, "entry inv");
    rdreg(4'h8);
    check(rd[4:1] === 4'h0, "set cleared");
    op(SMC_OP_DBLKINV, 32'h0001_5000, 32'h0, 4'h0, 1'b0);
    rdreg(4'h8);
    check(rd[4:1] === 4'h1, "other set kept");
  endtask

  task automatic t_sync();
    op(SMC_OP_TLBSYNC, 32'h0, 32'h0, 4'h0, 1'b0);
    check(fl === 7'b0000001 && cyc === 2, "idle sync");
    for (int i = 0; i < 64; i++)
      op(SMC_OP_TLBINV, i << 12, 32'h0, 4'h0, 1'b0);
    syncLen = 8'd10;
    @(posedge clk);
    syncLen <= 8'd0;
    op(SMC_OP_TLBSYNC, 32'h0, 32'h0, 4'h0, 1'b0);
    check(cyc === 10, "sync wait");
    rdreg(`SMC_OFF_STATUS);
    check(rd[`SMC_ST_SYNCDONE] === 1'b1, "sync flag");
  endtask

  task automatic t_illegal();
    op(SMC_OP_TLBINVALL, 32'h0, 32'h0, 4'h0, 1'b0);
    check(fl === 7'b1000001, "invalidate-all");
    rdreg(`SMC_OFF_STATUS);
    check(rd[`SMC_ST_ILLEGAL] === 1'b1, "illegal flag");
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    resetn = 1'b0;
    {opValid, opIndirect, fillStb, regWr, regRd, wantBlk, wantPage, wantHit} = 8'h00;
    opCode = SMC_OP_SEGRD;
    {opAddr, opData, regWdata} = 96'h0;
    {syncLen, fillIdx, opSeg, regAddr, fillWay} = 24'h0;
    err_count = 0;
    n_checks = 0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    t_regs();
    t_blkinv();
    t_faults();
    t_direct();
    t_segs();
    t_tlbinv();
    t_sync();
    t_illegal();
    tally_and_finish();
  end

  // about 300 cycles expected; cut a hang at 10000
  initial
  begin
    #50000;
    err_count++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
